/* File: verilog/dbts_defines.svh */
// Register offsets, field positions and reset values of the trigger block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef DBTS_DEFINES_SVH
`define DBTS_DEFINES_SVH

`define DBTS_OFS_CTRL      8'h00
`define DBTS_OFS_TRIG      8'h04
`define DBTS_OFS_STAT      8'h08

`define DBTS_CTRL_EN_BIT   7
`define DBTS_CTRL_ARM_BIT  6
`define DBTS_CTRL_TAG_BIT  5
`define DBTS_CTRL_BRK_BIT  4
`define DBTS_CTRL_RST      8'h00

`define DBTS_TRIG_TYPE_BIT 7
`define DBTS_TRIG_BEG_BIT  6
`define DBTS_TRIG_MODE_MSB 3
`define DBTS_TRIG_WR_MASK  8'hCF
`define DBTS_TRIG_RST      8'h00

`define DBTS_STAT_AF_BIT   7
`define DBTS_STAT_BF_BIT   6
`define DBTS_STAT_ARM_BIT  5
`define DBTS_STAT_CNT_MSB  3

`endif

/* File: verilog/dbts_pkg.sv */
// Types shared by the trigger-select block.
// Assumes nothing of its surroundings.
package dbts_pkg;

    typedef enum logic [3:0] {
        MODE_A_ONLY     = 4'b0000,
        MODE_A_OR_B     = 4'b0001,
        MODE_A_THEN_B   = 4'b0010,
        MODE_EVT_B      = 4'b0011,
        MODE_A_THEN_EVB = 4'b0100,
        MODE_A_AND_B    = 4'b0101,
        MODE_A_NOT_B    = 4'b0110,
        MODE_INSIDE     = 4'b0111,
        MODE_OUTSIDE    = 4'b1000
    } dbts_mode_t;

    typedef enum logic [1:0] {
        RUN_IDLE  = 2'b00,
        RUN_WAIT  = 2'b01,
        RUN_STORE = 2'b10
    } dbts_run_t;

endpackage : dbts_pkg

/* File: verilog/dbts_eval_if.sv */
// Carrier between the register/run controller and the trigger evaluator.
// Assumes both ends share one clock.
interface dbts_eval_if;
    logic [3:0] mode;
    logic       tag_sel;
    logic       armed;
    logic       run_start;
    logic       hit_a;
    logic       hit_b;
    logic       access;
    logic       below_a;
    logic       above_b;
    logic       op_exec;
    logic       op_flush;
    logic       trig_hit;
    logic       a_seen;
    logic       b_seen;
    logic       event_only;

    modport ctrl (output mode, tag_sel, armed, run_start, hit_a, hit_b,
                  access, below_a, above_b, op_exec, op_flush,
                  input  trig_hit, a_seen, b_seen, event_only);
    modport eval (input  mode, tag_sel, armed, run_start, hit_a, hit_b,
                  access, below_a, above_b, op_exec, op_flush,
                  output trig_hit, a_seen, b_seen, event_only);
endinterface : dbts_eval_if

/* File: verilog/dbts_trig_eval.sv */
// Trigger-mode decode, sequence memory and opcode tracking.
// Assumes comparator hits are one-cycle pulses on the shared clock.
module dbts_trig_eval (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Controller side
    dbts_eval_if.eval ev
);

    logic cond;
    logic a_seen_reg;
    logic b_seen_reg;
    logic pend_reg;

    // Mode decode; codes 1001..1111 fall to no trigger
    always_comb begin
        cond = 1'b0;
        case (dbts_pkg::dbts_mode_t'(ev.mode))
            dbts_pkg::MODE_A_ONLY:     cond = ev.hit_a;
            dbts_pkg::MODE_A_OR_B:     cond = ev.hit_a | ev.hit_b;
            dbts_pkg::MODE_A_THEN_B:   cond = ev.hit_b & a_seen_reg;
            dbts_pkg::MODE_EVT_B:      cond = ev.hit_b;
            dbts_pkg::MODE_A_THEN_EVB: cond = ev.hit_b & a_seen_reg;
            dbts_pkg::MODE_A_AND_B:    cond = ev.hit_a & ev.hit_b;
            dbts_pkg::MODE_A_NOT_B:    cond = ev.hit_a & ~ev.hit_b;
            dbts_pkg::MODE_INSIDE:
                cond = ev.access & ~ev.below_a & ~ev.above_b;
            dbts_pkg::MODE_OUTSIDE:
                cond = ev.access & (ev.below_a | ev.above_b);
            default:                   cond = 1'b0;
        endcase
    end

    assign ev.event_only = (ev.mode == 4'b0011) | (ev.mode == 4'b0100);

    // Sticky match memory; a hit in the start cycle survives the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            a_seen_reg <= 1'b0;
            b_seen_reg <= 1'b0;
        end else begin
            a_seen_reg <= (a_seen_reg & ~ev.run_start)
                        | ((ev.armed | ev.run_start) & ev.hit_a);
            b_seen_reg <= (b_seen_reg & ~ev.run_start)
                        | ((ev.armed | ev.run_start) & ev.hit_b);
        end
    end

    // Tagged match waits for the opcode to execute or be flushed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
        end else if (!ev.armed || !ev.tag_sel || ev.op_flush) begin
            pend_reg <= 1'b0;
        end else if (ev.op_exec) begin
            pend_reg <= cond;
        end else if (cond) begin
            pend_reg <= 1'b1;
        end
    end

    assign ev.trig_hit = ev.armed & (ev.tag_sel ? (pend_reg & ev.op_exec)
                                                : cond);
    assign ev.a_seen = a_seen_reg;
    assign ev.b_seen = b_seen_reg;

endmodule : dbts_trig_eval

/* File: verilog/dbts_trigger_select.sv */
// Trigger selection and run control of the on-chip debug unit, with an
// AHB-Lite register slave.
// Assumes comparators, opcode tracker and trace FIFO run on clk.
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`include "dbts_defines.svh"

module dbts_trigger_select (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Comparators
    input  wire logic        cmp_a_match,
    input  wire logic        cmp_b_match,
    input  wire logic        bus_access,
    input  wire logic        addr_below_a,
    input  wire logic        addr_above_b,
    // Opcode tracker
    input  wire logic        opcode_executed,
    input  wire logic        opcode_flushed,
    // Trace FIFO
    input  wire logic        fifo_full,
    input  wire logic [3:0]  fifo_count,
    // Run outputs
    output logic             trigger_event,
    output logic             capture_enable,
    output logic             begin_trace,
    output logic             break_request,
    output logic             break_tag_type,
    output logic             armed_status_flag
);

    // Reset release
    logic                rst_meta_reg;
    logic                rst_n_reg;

    // Bus pipeline
    logic                wr_pend_reg;
    logic [7:0]          wr_addr_reg;
    logic                addr_take;
    logic [7:0]          rd_byte;

    // Registers
    logic [7:0]          debug_control_reg;
    logic [7:0]          debug_trigger_config;
    logic [7:0]          debug_status_reg;
    logic                armed_reg;
    logic [3:0]          cnt_reg;
    dbts_pkg::dbts_run_t run_reg;

    // Decoded strobes
    logic                wr_ctrl;
    logic                wr_trig;
    logic                arm_req;
    logic                disarm_req;
    logic                run_start;
    logic                begin_eff;
    logic                trig_end;
    logic                full_end;
    logic                run_done;

    dbts_eval_if ev ();

    // Two-flop release of the asynchronous reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // Address phase accepted
    assign addr_take = hsel & hready & htrans[1];

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_take & hwrite;
            if (addr_take) begin
                wr_addr_reg <= haddr[7:0];
            end
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (haddr[7:0])
            `DBTS_OFS_CTRL: rd_byte = debug_control_reg;
            `DBTS_OFS_TRIG: rd_byte = debug_trigger_config;
            `DBTS_OFS_STAT: rd_byte = debug_status_reg;
            default:        rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            hrdata <= 32'h00000000;
        end else if (addr_take && !hwrite) begin
            hrdata <= {24'h000000, rd_byte};
        end
    end

    // Data-phase write strobes; status has none
    assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `DBTS_OFS_CTRL);
    assign wr_trig = wr_pend_reg & (wr_addr_reg == `DBTS_OFS_TRIG)
                   & ~armed_reg;

    // Arm and disarm requests from a control write
    assign arm_req    = wr_ctrl & hwdata[`DBTS_CTRL_EN_BIT]
                      & hwdata[`DBTS_CTRL_ARM_BIT];
    assign disarm_req = wr_ctrl & (~hwdata[`DBTS_CTRL_EN_BIT]
                      | ~hwdata[`DBTS_CTRL_ARM_BIT]);
    assign run_start  = arm_req & ~armed_reg;

    // Control register; arm bit copies the armed state one cycle late, held during control writes
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            debug_control_reg <= `DBTS_CTRL_RST;
        end else if (wr_ctrl) begin
            debug_control_reg[`DBTS_CTRL_EN_BIT]  <= hwdata[`DBTS_CTRL_EN_BIT];
            debug_control_reg[`DBTS_CTRL_TAG_BIT] <= hwdata[`DBTS_CTRL_TAG_BIT];
            debug_control_reg[`DBTS_CTRL_BRK_BIT] <= hwdata[`DBTS_CTRL_BRK_BIT];
            debug_control_reg[3:0]                <= hwdata[3:0];
        end else begin
            debug_control_reg[`DBTS_CTRL_ARM_BIT] <= armed_reg;
        end
    end

    // Trigger configuration; bits 5:4 masked to zero
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            debug_trigger_config <= `DBTS_TRIG_RST;
        end else if (wr_trig) begin
            debug_trigger_config <= hwdata[7:0]
                                  & `DBTS_TRIG_WR_MASK;
        end
    end

    // Evaluator hookup
    assign ev.mode      = debug_trigger_config[`DBTS_TRIG_MODE_MSB:0];
    assign ev.tag_sel   = debug_trigger_config[`DBTS_TRIG_TYPE_BIT];
    assign ev.armed     = armed_reg;
    assign ev.run_start = run_start;
    assign ev.hit_a     = cmp_a_match;
    assign ev.hit_b     = cmp_b_match;
    assign ev.access    = bus_access;
    assign ev.below_a   = addr_below_a;
    assign ev.above_b   = addr_above_b;
    assign ev.op_exec   = opcode_executed;
    assign ev.op_flush  = opcode_flushed;

    dbts_trig_eval u_eval (
        .clk   (clk),
        .rst_n (rst_n_reg),
        .ev    (ev.eval)
    );

    // Capture style; event-only modes force begin trace
    assign begin_eff = debug_trigger_config[`DBTS_TRIG_BEG_BIT]
                     | ev.event_only;

    // Run completion events
    assign trig_end = (run_reg == dbts_pkg::RUN_WAIT) & ev.trig_hit
                    & ~begin_eff;
    assign full_end = (run_reg == dbts_pkg::RUN_STORE) & fifo_full;
    assign run_done = trig_end | full_end;

    // Run state
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            run_reg <= dbts_pkg::RUN_IDLE;
        end else if (disarm_req) begin
            run_reg <= dbts_pkg::RUN_IDLE;
        end else begin
            case (run_reg)
                dbts_pkg::RUN_IDLE: begin
                    if (run_start) begin
                        run_reg <= dbts_pkg::RUN_WAIT;
                    end
                end
                dbts_pkg::RUN_WAIT: begin
                    if (ev.trig_hit) begin
                        run_reg <= begin_eff ? dbts_pkg::RUN_STORE
                                             : dbts_pkg::RUN_IDLE;
                    end
                end
                dbts_pkg::RUN_STORE: begin
                    if (fifo_full) begin
                        run_reg <= dbts_pkg::RUN_IDLE;
                    end
                end
                default: run_reg <= dbts_pkg::RUN_IDLE;
            endcase
        end
    end

    // Armed flag: software sets, completion or software clears
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            armed_reg <= 1'b0;
        end else if (disarm_req || run_done) begin
            armed_reg <= 1'b0;
        end else if (run_start) begin
            armed_reg <= 1'b1;
        end
    end

    // Valid count cleared at start, captured at completion
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            cnt_reg <= 4'h0;
        end else if (run_start) begin
            cnt_reg <= 4'h0;
        end else if (run_done || (disarm_req && armed_reg)) begin
            cnt_reg <= fifo_count;
        end
    end

    // Status image; bus writes never reach it
    always_comb begin
        debug_status_reg                      = 8'h00;
        debug_status_reg[`DBTS_STAT_AF_BIT]   = ev.a_seen;
        debug_status_reg[`DBTS_STAT_BF_BIT]   = ev.b_seen;
        debug_status_reg[`DBTS_STAT_ARM_BIT]  = armed_reg;
        debug_status_reg[`DBTS_STAT_CNT_MSB:0] = cnt_reg;
    end

    // Registered run outputs
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            trigger_event     <= 1'b0;
            capture_enable    <= 1'b0;
            begin_trace       <= 1'b0;
            armed_status_flag <= 1'b0;
            break_tag_type    <= 1'b0;
        end else begin
            trigger_event     <= (run_reg == dbts_pkg::RUN_WAIT)
                               & ev.trig_hit & ~disarm_req;
            capture_enable    <= begin_eff
                               ? (run_reg == dbts_pkg::RUN_STORE)
                               : (run_reg == dbts_pkg::RUN_WAIT);
            begin_trace       <= begin_eff;
            armed_status_flag <= armed_reg;
            break_tag_type    <= debug_control_reg[`DBTS_CTRL_TAG_BIT];
        end
    end

    // Break request one pulse at run end, if enabled
    always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            break_request <= 1'b0;
        end else begin
            break_request <= debug_control_reg[`DBTS_CTRL_BRK_BIT]
                           & run_done & ~disarm_req;
        end
    end

endmodule : dbts_trigger_select

/* File: verif/dbts_trig_asserts.sv */
// Port-level checker of the trigger-select block.
// Assumes binding onto the top module; bus offsets from the defines.
`include "dbts_defines.svh"
module dbts_trig_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hresp,
    // Run
    input wire logic        fifo_full,
    input wire logic        trigger_event,
    input wire logic        capture_enable,
    input wire logic        break_request,
    input wire logic        armed_status_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic take;
    logic ctrl_dp_reg;
    assign take = hsel && hready && htrans[1];
    // Data phase of a control write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_dp_reg <= 1'b0;
        end else if (hready) begin
            ctrl_dp_reg <= take && hwrite && haddr[7:0] == `DBTS_OFS_CTRL;
        end
    end
    a_trig_in_run: assert property (trigger_event |->
        $past(armed_status_flag)) else $error("trigger while unarmed");
    a_break_pulse: assert property (break_request |=>
        !break_request) else $error("break longer than one cycle");
    a_break_cause: assert property (break_request |->
        trigger_event || $past(fifo_full)) else $error("break without cause");
    a_cfg_rsvd_zero: assert property (take && !hwrite &&
        haddr[7:0] == `DBTS_OFS_TRIG |=> hrdata[5:4] == 2'h0)
        else $error("config bits 5:4 not zero");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_capture_run: assert property (capture_enable |->
        armed_status_flag || $past(armed_status_flag))
        else $error("capture outside a run");
    a_arm_by_write: assert property ($rose(armed_status_flag) |->
        $past(ctrl_dp_reg, 2)) else $error("armed without control write");
endmodule : dbts_trig_asserts

bind dbts_trigger_select dbts_trig_asserts u_chk (.clk, .reset_n, .hsel,
    .haddr, .htrans, .hwrite, .hready, .hrdata, .hresp, .fifo_full,
    .trigger_event, .capture_enable, .break_request, .armed_status_flag);

/* File: verif/dbts_far_model.sv */
// Comparators, opcode tracker and trace FIFO facing the block.
// Assumes the bench calls pulse for every hit it wants.
module dbts_far_model (
    // Clock and block side
    input  wire logic       clk,
    input  wire logic       capture_enable,
    // Comparators and tracker
    output logic            cmp_a_match,
    output logic            cmp_b_match,
    output logic            bus_access,
    output logic            addr_below_a,
    output logic            addr_above_b,
    output logic            opcode_executed,
    output logic            opcode_flushed,
    // Trace FIFO
    output logic            fifo_full,
    output logic      [3:0] fifo_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg = 4'h0;
    assign fifo_count = cnt_reg;
    assign fifo_full = cnt_reg == 4'h8;
    // One word stored per capture cycle, cleared between runs
    always_ff @(posedge clk) begin
        if (!capture_enable) begin
            cnt_reg <= 4'h0;
        end else if (!fifo_full) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    initial begin
        {cmp_a_match, cmp_b_match, bus_access, addr_below_a, addr_above_b,
         opcode_executed, opcode_flushed} = 7'h00;
    end
    task automatic pulse(input logic [6:0] s);
        @(posedge clk);
        {cmp_a_match, cmp_b_match, bus_access, addr_below_a, addr_above_b,
         opcode_executed, opcode_flushed} <= s;
        @(posedge clk);
        {cmp_a_match, cmp_b_match, bus_access, addr_below_a, addr_above_b,
         opcode_executed, opcode_flushed} <= 7'h00;
    endtask : pulse
endmodule : dbts_far_model

/* File: verif/test_debug_trigger_select.sv */
// Self-checking bench of the trigger-select block.
// Assumes the far-side model and the port checker beside it.
`include "dbts_defines.svh"
module test_debug_trigger_select;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h0;
    logic [31:0] hwdata = 32'h00000000;
    logic        hready, hreadyout, hresp, cmp_a_match, cmp_b_match;
    logic        bus_access, addr_below_a, addr_above_b, opcode_executed;
    logic        opcode_flushed, fifo_full, trigger_event, capture_enable;
    logic        begin_trace, break_request, break_tag_type;
    logic        armed_status_flag, seen, brk;
    logic [31:0] hrdata, rd;
    logic [3:0]  fifo_count;
    int          fails = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Mode, first hit, second hit, trigger expected; hits a,b,acc,lo,hi
    localparam logic [14:0] MODES [23] = '{
        {4'h0, 5'h10, 5'h00, 1'b1}, {4'h0, 5'h08, 5'h00, 1'b0},
        {4'h1, 5'h08, 5'h00, 1'b1}, {4'h2, 5'h08, 5'h00, 1'b0},
        {4'h2, 5'h10, 5'h08, 1'b1}, {4'h3, 5'h08, 5'h00, 1'b1},
        {4'h4, 5'h08, 5'h00, 1'b0}, {4'h4, 5'h10, 5'h08, 1'b1},
        {4'h5, 5'h18, 5'h00, 1'b1}, {4'h5, 5'h10, 5'h00, 1'b0},
        {4'h6, 5'h10, 5'h00, 1'b1}, {4'h6, 5'h18, 5'h00, 1'b0},
        {4'h7, 5'h04, 5'h00, 1'b1}, {4'h7, 5'h06, 5'h00, 1'b0},
        {4'h8, 5'h06, 5'h00, 1'b1}, {4'h8, 5'h04, 5'h00, 1'b0},
        {4'h9, 5'h1F, 5'h00, 1'b0}, {4'hA, 5'h1F, 5'h00, 1'b0},
        {4'hB, 5'h1F, 5'h00, 1'b0}, {4'hC, 5'h1F, 5'h00, 1'b0},
        {4'hD, 5'h1F, 5'h00, 1'b0}, {4'hE, 5'h1F, 5'h00, 1'b0},
        {4'hF, 5'h1F, 5'h00, 1'b0}};
    assign hready = hreadyout;
    dbts_trigger_select DUT (.clk(clk), .reset_n(reset_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .cmp_a_match(cmp_a_match),
        .cmp_b_match(cmp_b_match), .bus_access(bus_access),
        .addr_below_a(addr_below_a), .addr_above_b(addr_above_b),
        .opcode_executed(opcode_executed), .opcode_flushed(opcode_flushed),
        .fifo_full(fifo_full), .fifo_count(fifo_count),
        .trigger_event(trigger_event), .capture_enable(capture_enable),
        .begin_trace(begin_trace), .break_request(break_request),
        .break_tag_type(break_tag_type),
        .armed_status_flag(armed_status_flag));
    dbts_far_model u_far (.clk(clk), .capture_enable(capture_enable),
        .cmp_a_match(cmp_a_match), .cmp_b_match(cmp_b_match),
        .bus_access(bus_access), .addr_below_a(addr_below_a),
        .addr_above_b(addr_above_b), .opcode_executed(opcode_executed),
        .opcode_flushed(opcode_flushed), .fifo_full(fifo_full),
        .fifo_count(fifo_count));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic conclude;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end
    task automatic check(input logic [31:0] got, exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : check
    // One single transfer; read data lands in rd
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : xfer
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string m);
        xfer(a, 1'b0, 32'h00000000);
        check(rd, e, m);
    endtask : rd_chk
    task automatic watch(input int n);
        seen = 1'b0;
        brk = 1'b0;
        repeat (n) begin
            @(posedge clk);
            seen = seen | (trigger_event === 1'b1);
            brk = brk | (break_request === 1'b1);
        end
    endtask : watch
    task automatic t_regs;
        rd_chk(`DBTS_OFS_CTRL, 32'h00000000, "control reset");
        rd_chk(`DBTS_OFS_TRIG, 32'h00000000, "config reset");
        xfer(`DBTS_OFS_TRIG, 1'b1, 32'hFFFFFFFF);
        rd_chk(`DBTS_OFS_TRIG, 32'h000000CF, "config bits 5:4");
        xfer(`DBTS_OFS_STAT, 1'b1, 32'h000000FF);
        rd_chk(`DBTS_OFS_STAT, 32'h00000000, "status written");
        xfer(8'h0C, 1'b1, 32'h000000FF);
        rd_chk(8'h0C, 32'h00000000, "unmapped read");
        $display("test regs done");
    endtask : t_regs
    task automatic t_lock;
        xfer(`DBTS_OFS_TRIG, 1'b1, 32'h00000000);
        xfer(`DBTS_OFS_CTRL, 1'b1, 32'h000000C0);
        repeat (2) @(posedge clk);
        check(capture_enable, 1'b1, "end trace capture");
        check(armed_status_flag, 1'b1, "armed by write");
        rd_chk(`DBTS_OFS_CTRL, 32'h000000C0, "arm reads back");
        xfer(`DBTS_OFS_TRIG, 1'b1, 32'h00000005);
        rd_chk(`DBTS_OFS_TRIG, 32'h00000000, "config locked");
        xfer(`DBTS_OFS_CTRL, 1'b1, 32'h00000040);
        repeat (2) @(posedge clk);
        check(armed_status_flag, 1'b0, "enable off disarms");
        xfer(`DBTS_OFS_TRIG, 1'b1, 32'h00000005);
        rd_chk(`DBTS_OFS_TRIG, 32'h00000005, "config unlocked");
        $display("test lock done");
    endtask : t_lock
    task automatic t_modes;
        logic [14:0] e;
        logic        evo;
        for (int i = 0; i < 23; i++) begin
            e = MODES[i];
            evo = (e[14:11] == 4'h3) || (e[14:11] == 4'h4);
            xfer(`DBTS_OFS_TRIG, 1'b1, {28'h0000000, e[14:11]});
            xfer(`DBTS_OFS_CTRL, 1'b1, 32'h000000D0);
            u_far.pulse({e[10:6], 2'h0});
            if (e[5:1] != 5'h00) begin
                u_far.pulse({e[5:1], 2'h0});
            end
            watch(4);
            check(seen, e[0], "mode");
            if (e[0] && !evo) begin
                check(brk, 1'b1, "break at trigger");
            end
            check(begin_trace, evo, "event-only begin");
            xfer(`DBTS_OFS_CTRL, 1'b1, 32'h00000080);
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_tag;
        xfer(`DBTS_OFS_TRIG, 1'b1, 32'h00000080);
        xfer(`DBTS_OFS_CTRL, 1'b1, 32'h000000F0);
        u_far.pulse(7'h40);
        watch(4);
        check(seen, 1'b0, "tag waits for opcode");
        check(break_tag_type, 1'b1, "tag break type");
        u_far.pulse(7'h02);
        watch(3);
        check(seen, 1'b1, "tag opcode executed");
        xfer(`DBTS_OFS_CTRL, 1'b1, 32'h000000F0);
        u_far.pulse(7'h40);
        u_far.pulse(7'h01);
        u_far.pulse(7'h02);
        watch(4);
        check(seen, 1'b0, "tag flushed");
        xfer(`DBTS_OFS_CTRL, 1'b1, 32'h00000080);
        $display("test tag done");
    endtask : t_tag
    task automatic t_begin;
        xfer(`DBTS_OFS_TRIG, 1'b1, 32'h00000040);
        xfer(`DBTS_OFS_CTRL, 1'b1, 32'h000000D0);
        @(posedge clk);
        check(capture_enable, 1'b0, "begin waits");
        check(begin_trace, 1'b1, "begin select");
        u_far.pulse(7'h40);
        watch(30);
        check(brk, 1'b1, "break at full");
        rd_chk(`DBTS_OFS_STAT, 32'h00000088, "run complete");
        $display("test begin done");
    endtask : t_begin
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_regs();
        t_lock();
        t_modes();
        t_tag();
        t_begin();
        conclude();
    end
endmodule : test_debug_trigger_select
